// >>> rtl/pmg_pkg.sv
package pmg_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_PERIOD = 8'h04;
  localparam logic [7:0]  OFF_WIDTH  = 8'h08;
  localparam logic [7:0]  OFF_DWIDTH = 8'h0C;
  localparam logic [7:0]  OFF_DELAY  = 8'h10;
  localparam logic [7:0]  OFF_DDELAY = 8'h14;
  localparam logic [7:0]  OFF_STATUS = 8'h18;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ==========================================================
  // Control field layout and codes
  localparam int          CTRL_W     = 11;
  localparam int          STAT_MOD   = 0;
  localparam int          STAT_RUN   = 1;
  localparam int          STAT_SETL  = 2;
  localparam int          STAT_VID   = 3;
  localparam logic [1:0]  MULTIPURPOSE_IO_CONNECTOR_AUTO   = 2'h0;
  localparam logic [1:0]  MULTIPURPOSE_IO_CONNECTOR_SINGLE = 2'h1;
  localparam logic [1:0]  MULTIPURPOSE_IO_CONNECTOR_GATED  = 2'h2;
  localparam logic [2:0]  CONN_SETTLED   = 3'h0;
  localparam logic [2:0]  CONN_UNSETTLED = 3'h1;
  localparam logic [2:0]  CONN_VIDEO     = 3'h2;
  localparam logic [2:0]  CONN_MULTIPURPOSE_IO_CONNECTOR_IN   = 3'h3;
  localparam logic [2:0]  CONN_EXT_SRC   = 3'h4;
  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_PERIOD = 32'h0000_0064;
  localparam logic [31:0] RST_WIDTH  = 32'h0000_000A;
  localparam logic [31:0] RST_DWIDTH = 32'h0000_000A;
  localparam logic [31:0] RST_DELAY  = 32'h0000_0000;
  localparam logic [31:0] RST_DDELAY = 32'h0000_0032;
  // ==========================================================
  // Types
  typedef struct packed {
    logic [2:0] conn;
    logic       gate_low;
    logic       slope_fall;
    logic [1:0] multipurpose_io_connector;
    logic       dbl;
    logic       ext_inv;
    logic       src_ext;
    logic       enable;
  } pmg_ctrl_s;
  typedef struct packed {
    logic [31:0] period;
    logic [31:0] width;
    logic [31:0] dwidth;
    logic [31:0] delay;
    logic [31:0] ddelay;
  } pmg_time_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } pmg_state_e;
endpackage : pmg_pkg

// >>> rtl/pmg_top.sv
module pmg_top
  import pmg_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [DATA_W-1:0]      s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic              settled_i,
  input  wire logic              mpio_i,
  output logic                   mpio_o,
  output logic                   mpio_oe_o,
  output logic                   mod_o
);

  // ==========================================================
  // Declarations
  pmg_ctrl_s          ctrl_q;
  pmg_time_s          tim_q;
  pmg_state_e         state_q;
  logic [31:0]        cnt_q;
  logic               pulse_q;
  logic               mod_q;
  logic               mpio_q;
  logic               mpio_oe_q;
  logic               sync1_q;
  logic               sync2_q;
  logic               sync3_q;
  logic               aw_q;
  logic               w_q;
  logic [ADDR_W-1:0]  aw_addr_q;
  logic [DATA_W-1:0]  w_data_q;
  logic [3:0]         w_strb_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic               rvalid_q;
  logic [DATA_W-1:0]  rdata_q;
  logic [1:0]         rresp_q;
  logic               aw_hs;
  logic               w_hs;
  logic               do_wr;
  logic [ADDR_W-1:0]  wr_addr;
  logic [DATA_W-1:0]  wr_data;
  logic [3:0]         wr_strb;
  logic               wr_hit;
  logic               multipurpose_io_connector_sel;
  logic               src_sel;
  logic               multipurpose_io_connector_evt;
  logic               gate_act;
  logic               ext_level;
  logic               gen_en;
  logic [31:0]        per_m1;
  logic               wrap;
  logic               win1;
  logic               win2;
  logic               stop_run;
  logic [DATA_W-1:0]  rd_mux;
  logic               rd_hit;
  logic [DATA_W-1:0]  ctrl_wr;

  function automatic logic [31:0] wmerge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : wmerge

  // ==========================================================
  // AXI4-Lite write channel
  assign s_axi_awready_o = !aw_q && !bvalid_q;
  assign s_axi_wready_o  = !w_q && !bvalid_q;
  assign aw_hs   = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs    = s_axi_wvalid_i && s_axi_wready_o;
  assign do_wr   = (aw_q || aw_hs) && (w_q || w_hs);
  assign wr_addr = aw_q ? aw_addr_q : s_axi_awaddr_i;
  assign wr_data = w_q ? w_data_q : s_axi_wdata_i;
  assign wr_strb = w_q ? w_strb_q : s_axi_wstrb_i;
  assign wr_hit  = (wr_addr == OFF_CTRL) || (wr_addr == OFF_PERIOD)
                || (wr_addr == OFF_WIDTH) || (wr_addr == OFF_DWIDTH)
                || (wr_addr == OFF_DELAY) || (wr_addr == OFF_DDELAY);
  assign ctrl_wr = wmerge({21'h0, ctrl_q}, wr_data, wr_strb);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aw_q      <= 1'b0;
      w_q       <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end
    else
    begin
      aw_q <= do_wr ? 1'b0 : (aw_q || aw_hs);
      w_q  <= do_wr ? 1'b0 : (w_q || w_hs);
      if (aw_hs)
      begin
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (w_hs)
      begin
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready_i)
    begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o  = bresp_q;

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= '0;
      tim_q  <= '{RST_PERIOD, RST_WIDTH, RST_DWIDTH, RST_DELAY, RST_DDELAY};
    end
    else if (do_wr)
    begin
      case (wr_addr)
        OFF_CTRL:   ctrl_q <= pmg_ctrl_s'(ctrl_wr[CTRL_W-1:0]);
        OFF_PERIOD: tim_q.period <= wmerge(tim_q.period, wr_data, wr_strb);
        OFF_WIDTH:  tim_q.width  <= wmerge(tim_q.width, wr_data, wr_strb);
        OFF_DWIDTH: tim_q.dwidth <= wmerge(tim_q.dwidth, wr_data, wr_strb);
        OFF_DELAY:  tim_q.delay  <= wmerge(tim_q.delay, wr_data, wr_strb);
        OFF_DDELAY: tim_q.ddelay <= wmerge(tim_q.ddelay, wr_data, wr_strb);
        default:    ctrl_q <= ctrl_q;
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign s_axi_arready_o = !rvalid_q;

  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = '0;
    case (s_axi_araddr_i)
      OFF_CTRL:   rd_mux = {21'h0, ctrl_q};
      OFF_PERIOD: rd_mux = tim_q.period;
      OFF_WIDTH:  rd_mux = tim_q.width;
      OFF_DWIDTH: rd_mux = tim_q.dwidth;
      OFF_DELAY:  rd_mux = tim_q.delay;
      OFF_DDELAY: rd_mux = tim_q.ddelay;
      OFF_STATUS:
      begin
        rd_mux[STAT_MOD]  = mod_q;
        rd_mux[STAT_RUN]  = (state_q == ST_RUN);
        rd_mux[STAT_SETL] = settled_i;
        rd_mux[STAT_VID]  = pulse_q;
      end
      default:    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready_i)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o  = rdata_q;
  assign s_axi_rresp_o  = rresp_q;

  // ==========================================================
  // Connector input synchroniser and edge detect
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= mpio_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign multipurpose_io_connector_sel  = (ctrl_q.conn == CONN_MULTIPURPOSE_IO_CONNECTOR_IN);
  assign src_sel   = (ctrl_q.conn == CONN_EXT_SRC);
  assign multipurpose_io_connector_evt  = multipurpose_io_connector_sel && (ctrl_q.slope_fall ? (sync3_q && !sync2_q)
                                                     : (!sync3_q && sync2_q));
  assign gate_act  = multipurpose_io_connector_sel && (sync2_q ^ ctrl_q.gate_low);
  assign ext_level = sync2_q ^ ctrl_q.ext_inv;

  // ==========================================================
  // Pulse generator
  assign gen_en   = ctrl_q.enable && !ctrl_q.src_ext;
  assign per_m1   = (tim_q.period == 32'h0) ? 32'h0 : tim_q.period - 32'h1;
  assign wrap     = (cnt_q >= per_m1);
  // Double mode starts at count zero, the delay has no effect
  assign win1     = ctrl_q.dbl ? (cnt_q < tim_q.width)
                  : ((cnt_q >= tim_q.delay)
                  && ((cnt_q - tim_q.delay) < tim_q.width));
  assign win2     = ctrl_q.dbl && (cnt_q >= tim_q.ddelay)
                  && ((cnt_q - tim_q.ddelay) < tim_q.dwidth);
  assign stop_run = !gen_en
                  || ((ctrl_q.multipurpose_io_connector == MULTIPURPOSE_IO_CONNECTOR_GATED) && !gate_act)
                  || ((ctrl_q.multipurpose_io_connector == MULTIPURPOSE_IO_CONNECTOR_SINGLE) && wrap);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (gen_en && ((ctrl_q.multipurpose_io_connector == MULTIPURPOSE_IO_CONNECTOR_AUTO)
              || ((ctrl_q.multipurpose_io_connector == MULTIPURPOSE_IO_CONNECTOR_SINGLE) && multipurpose_io_connector_evt)
              || ((ctrl_q.multipurpose_io_connector == MULTIPURPOSE_IO_CONNECTOR_GATED) && gate_act)))
          begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (stop_run)
          begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cnt_q <= '0;
    end
    else if ((state_q != ST_RUN) || stop_run || wrap)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pulse_q <= 1'b0;
    end
    else
    begin
      pulse_q <= (state_q == ST_RUN) && (win1 || win2);
    end
  end

  // ==========================================================
  // Modulation output and connector driver
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mod_q <= 1'b1;
    end
    else if (!ctrl_q.enable)
    begin
      mod_q <= 1'b1;
    end
    else if (ctrl_q.src_ext)
    begin
      mod_q <= src_sel && ext_level;
    end
    else
    begin
      mod_q <= pulse_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mpio_q    <= 1'b0;
      mpio_oe_q <= 1'b0;
    end
    else
    begin
      case (ctrl_q.conn)
        CONN_SETTLED:   mpio_q <= settled_i;
        CONN_UNSETTLED: mpio_q <= !settled_i;
        CONN_VIDEO:     mpio_q <= pulse_q;
        default:        mpio_q <= 1'b0;
      endcase
      mpio_oe_q <= (ctrl_q.conn == CONN_SETTLED) || (ctrl_q.conn == CONN_UNSETTLED)
                || (ctrl_q.conn == CONN_VIDEO);
    end
  end

  assign mod_o     = mod_q;
  assign mpio_o    = mpio_q;
  assign mpio_oe_o = mpio_oe_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_armed;
    (state_q == ST_IDLE) && gen_en && (ctrl_q.multipurpose_io_connector == MULTIPURPOSE_IO_CONNECTOR_SINGLE);
  endsequence
  sequence s_fired;
    multipurpose_io_connector_evt;
  endsequence

  AST_DISABLED_PASS: assert property (!ctrl_q.enable |=> mod_o)
    else $error("Disabled modulation not in pass state");
  AST_SETTLED: assert property (!reset_i && (ctrl_q.conn == CONN_SETTLED)
                                |=> mpio_oe_o && (mpio_o == $past(settled_i)))
    else $error("Settled output wrong");
  AST_UNSETTLED: assert property ((ctrl_q.conn == CONN_UNSETTLED) |=> mpio_o != $past(settled_i))
    else $error("Unsettled output wrong");
  AST_VIDEO: assert property ((ctrl_q.conn == CONN_VIDEO) |=> mpio_o == $past(pulse_q))
    else $error("Video output does not follow pulse");
  AST_INPUT_HIZ: assert property ((multipurpose_io_connector_sel || src_sel) |=> !mpio_oe_o)
    else $error("Connector driven while an input");
  AST_EXT_SRC: assert property (ctrl_q.enable && ctrl_q.src_ext && src_sel |=> mod_o == $past(ext_level))
    else $error("External source not followed");
  AST_AUTO_RUN: assert property (gen_en && (ctrl_q.multipurpose_io_connector == MULTIPURPOSE_IO_CONNECTOR_AUTO) && (state_q == ST_IDLE) |=> state_q == ST_RUN)
    else $error("Auto mode did not start");
  AST_MULTIPURPOSE_IO_CONNECTOR_START: assert property (s_armed ##0 s_fired |=> state_q == ST_RUN)
    else $error("Trigger edge did not start the generator");
  AST_SINGLE_END: assert property ((state_q == ST_RUN) && (ctrl_q.multipurpose_io_connector == MULTIPURPOSE_IO_CONNECTOR_SINGLE) && wrap |=> state_q == ST_IDLE)
    else $error("Single trigger ran past one period");
  AST_WRAP: assert property ((state_q == ST_RUN) && wrap |=> cnt_q == 32'h0)
    else $error("Counter did not wrap at period");
  AST_FIRST_EDGE: assert property ((state_q == ST_RUN) && !ctrl_q.dbl && (cnt_q == tim_q.delay)
                                   && (tim_q.width != 32'h0) |=> pulse_q)
    else $error("Pulse did not start after delay");
  AST_SECOND_EDGE: assert property ((state_q == ST_RUN) && ctrl_q.dbl && (cnt_q == tim_q.ddelay)
                                    && (tim_q.dwidth != 32'h0) |=> pulse_q)
    else $error("Second pulse did not start");
  AST_GATE_STOP: assert property ((state_q == ST_RUN) && (ctrl_q.multipurpose_io_connector == MULTIPURPOSE_IO_CONNECTOR_GATED) && !gate_act
                                  |=> (state_q == ST_IDLE) ##1 !pulse_q)
    else $error("Gate did not stop the generator");

endmodule : pmg_top

// >>> verification/pmg_conn_model.sv
module pmg_conn_model
(
  input  wire logic clk_i,
  input  wire logic dev_val_i,
  input  wire logic dev_oe_i,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Pin drive and release
  logic drv_en_q  = 1'b0;
  logic drv_val_q = 1'b0;
  logic last_q    = 1'b0;
  // Released line shows the inverse of the last value the device drove until drive is first called, then the driven value
  always_ff @(posedge clk_i)
  begin
    if (dev_oe_i)
    begin
      last_q <= dev_val_i;
    end
  end
  assign pin_o = dev_oe_i ? dev_val_i : (drv_en_q ? drv_val_q : !last_q);
  // Called right after a rising edge
  task automatic drive(input logic v);
    drv_en_q  <= 1'b1;
    drv_val_q <= v;
  endtask : drive
endmodule : pmg_conn_model

// >>> verification/tb_top.sv
module tb_top
  import pmg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  localparam logic [31:0] PER  = 32'h14;
  localparam logic [31:0] WID  = 32'h5;
  localparam logic [31:0] DWID = 32'h4;
  localparam logic [31:0] DLY  = 32'h7;
  localparam logic [31:0] DDLY = 32'h9;
  logic        clk_i   = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  awaddr  = 8'h0;
  logic [7:0]  araddr  = 8'h0;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        settled = 1'b1;
  logic [31:0] rdata;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pin, mpio_o, mpio_oe, mod;
  int          miscompares = 0;
  int          n_tests     = 0;
  int          cyc         = 0;
  int          r [6];
  int          f [6];
  pmg_top dut
  (
    .clk_i           (clk_i),
    .reset_i         (reset_i),
    .s_axi_awaddr_i  (awaddr),
    .s_axi_awvalid_i (awvalid),
    .s_axi_awready_o (awready),
    .s_axi_wdata_i   (wdata),
    .s_axi_wstrb_i   (4'hF),
    .s_axi_wvalid_i  (wvalid),
    .s_axi_wready_o  (wready),
    .s_axi_bresp_o   (bresp),
    .s_axi_bvalid_o  (bvalid),
    .s_axi_bready_i  (bready),
    .s_axi_araddr_i  (araddr),
    .s_axi_arvalid_i (arvalid),
    .s_axi_arready_o (arready),
    .s_axi_rdata_o   (rdata),
    .s_axi_rresp_o   (rresp),
    .s_axi_rvalid_o  (rvalid),
    .s_axi_rready_i  (rready),
    .settled_i       (settled),
    .mpio_i          (pin),
    .mpio_o          (mpio_o),
    .mpio_oe_o       (mpio_oe),
    .mod_o           (mod)
  );
  pmg_conn_model model
  (
    .clk_i     (clk_i),
    .dev_val_i (mpio_o),
    .dev_oe_i  (mpio_oe),
    .pin_o     (pin)
  );
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
  end
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] rs;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs)
    begin
      @(negedge clk_i);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = (bvalid === 1'b1);
      rs = bresp;
      @(posedge clk_i);
      if (aw_hs)
        awvalid <= 1'b0;
      if (w_hs)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(32'(rs), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    logic ar_hs, r_hs;
    logic [1:0] rs;
    logic [31:0] d;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs)
    begin
      @(negedge clk_i);
      ar_hs = arvalid && arready;
      r_hs = (rvalid === 1'b1);
      rs = rresp;
      d = rdata;
      @(posedge clk_i);
      if (ar_hs)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(32'(rs), 32'(er));
    chk(d, ed);
  endtask : rd
  function automatic logic pick(input bit s);
    return s ? mpio_o : mod;
  endfunction : pick
  task automatic edge_at(input bit s, input logic v, output int t);
    do
      @(negedge clk_i);
    while (pick(s) !== !v);
    do
      @(negedge clk_i);
    while (pick(s) !== v);
    t = cyc;
  endtask : edge_at
  task automatic quiet(input bit s, input logic v, input int n);
    bit bad;
    bad = 1'b0;
    repeat (n)
    begin
      @(negedge clk_i);
      if (pick(s) !== v)
        bad = 1'b1;
    end
    chk(32'(bad), 32'h0);
  endtask : quiet
  task automatic multipurpose_io_connector(input logic v, output int t);
    @(posedge clk_i);
    model.drive(v);
    @(negedge clk_i);
    t = cyc;
  endtask : multipurpose_io_connector
  task automatic pulse_lat(input logic v, input bit dbl, output int lat);
    int t0, t1;
    multipurpose_io_connector(v, t0);
    edge_at(1'b0, 1'b1, t1);
    lat = t1 - t0;
    multipurpose_io_connector(!v, t0);
    edge_at(1'b0, 1'b0, t0);
    if (dbl)
    begin
      edge_at(1'b0, 1'b1, t0);
      chk(32'(t0 - t1), DDLY);
      edge_at(1'b0, 1'b0, t0);
    end
    quiet(1'b0, 1'b0, 40);
  endtask : pulse_lat
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(OFF_STATUS, RESP_OKAY, 32'h0000_0005);
    rd(OFF_CTRL, RESP_OKAY, 32'h0);
    rd(OFF_PERIOD, RESP_OKAY, RST_PERIOD);
    rd(OFF_WIDTH, RESP_OKAY, RST_WIDTH);
    rd(OFF_DWIDTH, RESP_OKAY, RST_DWIDTH);
    rd(OFF_DELAY, RESP_OKAY, RST_DELAY);
    rd(OFF_DDELAY, RESP_OKAY, RST_DDELAY);
    rd(8'h1C, RESP_SLVERR, 32'h0);
    wr(OFF_STATUS, 32'hF, RESP_SLVERR);
    wr(OFF_CTRL, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_CTRL, RESP_OKAY, 32'h0000_07FF);
    $display("test regs done");
  endtask : t_regs
  task automatic t_pat(input logic [31:0] ctrl, input bit s, input bit dbl);
    int k;
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    wr(OFF_CTRL, ctrl, RESP_OKAY);
    for (int i = 0; i < 6; i++)
    begin
      edge_at(s, 1'b1, r[i]);
      edge_at(s, 1'b0, f[i]);
    end
    k = (dbl && r[2] - r[1] != DDLY) ? 2 : 1;
    chk(32'(f[k] - r[k]), WID);
    if (dbl)
    begin
      chk(32'(r[k+1] - r[k]), DDLY);
      chk(32'(f[k+1] - r[k+1]), DWID);
      chk(32'(r[k+2] - r[k]), PER);
    end
    else
      chk(32'(r[k+1] - r[k]), PER);
    if (s)
      chk(32'(mpio_oe), 32'h1);
    $display("test pattern %h done", ctrl);
  endtask : t_pat
  task automatic setl(input logic v, input logic e);
    @(posedge clk_i);
    settled <= v;
    repeat (4) @(negedge clk_i);
    chk(32'(mpio_o), 32'(e));
    chk(32'(mpio_oe), 32'h1);
  endtask : setl
  task automatic t_conn();
    wr(OFF_CTRL, 32'h000, RESP_OKAY);
    setl(1'b0, 1'b0);
    setl(1'b1, 1'b1);
    wr(OFF_CTRL, 32'h100, RESP_OKAY);
    setl(1'b1, 1'b0);
    setl(1'b0, 1'b1);
    @(posedge clk_i);
    settled <= 1'b1;
    $display("test connector done");
  endtask : t_conn
  task automatic t_multipurpose_io_connector();
    int t0, t1, l0;
    multipurpose_io_connector(1'b0, t0);
    wr(OFF_DELAY, 32'h0, RESP_OKAY);
    wr(OFF_CTRL, 32'h311, RESP_OKAY);
    repeat (4) @(negedge clk_i);
    chk(32'(mpio_oe), 32'h0);
    pulse_lat(1'b1, 1'b0, l0);
    wr(OFF_DELAY, DLY, RESP_OKAY);
    pulse_lat(1'b1, 1'b0, t1);
    chk(32'(t1), 32'(l0) + DLY);
    wr(OFF_CTRL, 32'h319, RESP_OKAY);
    pulse_lat(1'b1, 1'b1, t1);
    chk(32'(t1), 32'(l0));
    wr(OFF_CTRL, 32'h351, RESP_OKAY);
    multipurpose_io_connector(1'b1, t0);
    quiet(1'b0, 1'b0, 30);
    pulse_lat(1'b0, 1'b0, t1);
    chk(32'(t1), 32'(l0) + DLY);
    $display("test trigger done");
  endtask : t_multipurpose_io_connector
  task automatic t_gate(input logic [31:0] ctrl, input logic act);
    int t;
    multipurpose_io_connector(act, t);
    t_pat(ctrl, 1'b0, 1'b0);
    multipurpose_io_connector(!act, t);
    repeat (8) @(negedge clk_i);
    quiet(1'b0, 1'b0, 40);
  endtask : t_gate
  task automatic t_ext(input logic [31:0] ctrl, input logic inv);
    int t;
    wr(OFF_CTRL, ctrl, RESP_OKAY);
    multipurpose_io_connector(1'b1, t);
    repeat (6) @(negedge clk_i);
    chk(32'(mod), 32'(!inv));
    multipurpose_io_connector(1'b0, t);
    repeat (6) @(negedge clk_i);
    chk(32'(mod), 32'(inv));
    $display("test external %h done", ctrl);
  endtask : t_ext
  // ==========================================================
  // Sequence and verdict
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    wr(OFF_CTRL, 32'h310, RESP_OKAY);
    quiet(1'b0, 1'b1, 40);
    wr(OFF_PERIOD, PER, RESP_OKAY);
    wr(OFF_WIDTH, WID, RESP_OKAY);
    wr(OFF_DWIDTH, DWID, RESP_OKAY);
    wr(OFF_DELAY, DLY, RESP_OKAY);
    wr(OFF_DDELAY, DDLY, RESP_OKAY);
    t_pat(32'h001, 1'b0, 1'b0);
    t_pat(32'h009, 1'b0, 1'b1);
    t_pat(32'h201, 1'b1, 1'b0);
    t_conn();
    t_multipurpose_io_connector();
    t_gate(32'h321, 1'b1);
    t_gate(32'h3A1, 1'b0);
    t_ext(32'h403, 1'b0);
    t_ext(32'h407, 1'b1);
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    $display("watchdog expired at %0t", $time);
    tally_and_finish();
  end
endmodule : tb_top
